// file: fpd_top.sv
// Fault passage detector for one feeder with sensitive-ground channel
// Overview of operation
// - Latch directional flags from first pickup onward
// - Delay after pickups drop, require voltage absence
// - Expired timer without condition returns to idle
// - Fault pulse lasts configured pulse width, up to one tick shorter
// - Direction outputs held until hold time or new fault
// - New fault rests direction outputs 2 ms first
// - Equal forward and reverse flags mean invalid
// - No valid unit gives zero direction, invalid
// - Disagreeing units give zero direction, invalid
// - Agreement sets valid, forward gives one
// - Direction computed when activation delay expires
// - Phase and ground direction reporting enables
// - Independent sensitive-ground detector, no direction
// - Three local indications follow remote indication
// - Local hold counted from voltage presence
// - Detector disabled forces telecontrol outputs zero plus invalid
// - Voltage detector disabled forces all invalid
// - Sensitive ground disabled invalidates its output only
// - No overcurrent enabled invalidates main three outputs
// - Pulse width 0 to 60 s, default 1 ms
// - Direction hold 0 to 3600 s, default 600 s
// - Local hold 0 to 150 min, default 10 min
// - One unit's pickup never inhibits others
// - Idle until validity check passes, log start
`timescale 1ns/1ps
module fpd_top #(
   parameter int TICK_CYCLES = fpd_pkg::TICK_CYCLES,
   parameter int NUM_OC      = fpd_pkg::NUM_OC,
   parameter int NUM_DIR     = fpd_pkg::NUM_DIR
) (
   input  wire logic               clk_sys_i,
   input  wire logic               rst_i,
   // Register port
   input  wire logic [7:0]         reg_addr_i,
   input  wire logic [31:0]        reg_wdata_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   output logic      [31:0]        reg_rdata_o,
   // Measurement units (same clock domain)
   input  wire logic [NUM_OC-1:0]  oc_pickup_i,
   input  wire logic               sg_pickup_i,
   input  wire logic [NUM_DIR-1:0] dir_fwd_i,
   input  wire logic [NUM_DIR-1:0] dir_rev_i,
   input  wire logic               volt_absent_i,
   input  wire logic               volt_present_i,
   input  wire logic               self_check_ok_i,
   output logic                    start_event_o,
   // Telecontrol
   output logic                    fault_passage_pulse_o,
   output logic                    fault_direction_out_o,
   output logic                    direction_valid_out_o,
   output logic                    sens_ground_fault_pulse_o,
   output logic                    fault_bad_o,
   output logic                    direction_bad_o,
   output logic                    valid_bad_o,
   output logic                    sens_ground_bad_o,
   // Local indications
   output logic                    local_fault_o,
   output logic                    local_valid_o,
   output logic                    local_direction_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Settings
   logic [fpd_pkg::CTRL_W-1:0]  ctrl;
   logic [NUM_OC-1:0]           oc_en;
   logic [fpd_pkg::ACT_W-1:0]   act_ms;
   logic [fpd_pkg::PUL_W-1:0]   pul_ms;
   logic [fpd_pkg::DES_W-1:0]   des_ms;
   logic [fpd_pkg::LOCAL_W-1:0] local_steps;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctrl        <= fpd_pkg::CTRL_RST;
         oc_en       <= NUM_OC'(fpd_pkg::OC_EN_RST);
         act_ms      <= fpd_pkg::ACT_RST;
         pul_ms      <= fpd_pkg::PUL_RST;
         des_ms      <= fpd_pkg::DES_RST;
         local_steps <= fpd_pkg::LOCAL_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == fpd_pkg::ADDR_CTRL) begin
            ctrl <= reg_wdata_i[fpd_pkg::CTRL_W-1:0];
         end else if (reg_addr_i == fpd_pkg::ADDR_OC_EN) begin
            oc_en <= reg_wdata_i[NUM_OC-1:0];
         end else if (reg_addr_i == fpd_pkg::ADDR_ACT) begin
            act_ms <= reg_wdata_i[fpd_pkg::ACT_W-1:0];
         end else if (reg_addr_i == fpd_pkg::ADDR_PUL) begin
            pul_ms <= reg_wdata_i[fpd_pkg::PUL_W-1:0];
         end else if (reg_addr_i == fpd_pkg::ADDR_DES) begin
            des_ms <= reg_wdata_i[fpd_pkg::DES_W-1:0];
         end else if (reg_addr_i == fpd_pkg::ADDR_LOCAL) begin
            local_steps <= reg_wdata_i[fpd_pkg::LOCAL_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Validity of telecontrol signals
   logic fpd_en;
   logic main_bad;
   logic sg_bad;
   logic started;

   assign fpd_en   = ctrl[fpd_pkg::CTRL_ENABLE];
   assign main_bad = !fpd_en || !ctrl[fpd_pkg::CTRL_VP_EN] || !ctrl[fpd_pkg::CTRL_VA_EN]
                     || !(|oc_en);
   assign sg_bad   = !fpd_en || !ctrl[fpd_pkg::CTRL_VP_EN] || !ctrl[fpd_pkg::CTRL_VA_EN]
                     || !ctrl[fpd_pkg::CTRL_SG_EN];

   // Start-up: stay idle until the validity check passes once
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         started <= 1'b0;
      end else if (self_check_ok_i) begin
         started <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         start_event_o <= 1'b0;
      end else begin
         start_event_o <= self_check_ok_i && !started;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Tick and sequencers
   logic tick;
   logic any_pickup;
   logic main_idle;
   logic main_declare;
   logic main_fire;
   logic main_pulse;
   logic sg_declare;
   logic sg_pulse;
   logic held;

   // Each unit feeds the OR on its own; a pickup never masks another
   assign any_pickup = |(oc_pickup_i & oc_en);

   fpd_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .tick_o    (tick)
   );

   fpd_seq u_main (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .run_i       (started && !main_bad),
      .tick_i      (tick),
      .pickup_i    (any_pickup),
      .absent_i    (volt_absent_i),
      .hold_busy_i (held),
      .act_ms_i    (act_ms),
      .pul_ms_i    (pul_ms),
      .idle_o      (main_idle),
      .declare_o   (main_declare),
      .fire_o      (main_fire),
      .pulse_o     (main_pulse)
   );

   // Sensitive-ground channel: same timing, no direction
   fpd_seq u_sens (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .run_i       (started && !sg_bad),
      .tick_i      (tick),
      .pickup_i    (sg_pickup_i),
      .absent_i    (volt_absent_i),
      .hold_busy_i (1'b0),
      .act_ms_i    (act_ms),
      .pul_ms_i    (pul_ms),
      .idle_o      (),
      .declare_o   (sg_declare),
      .fire_o      (),
      .pulse_o     (sg_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Direction accumulation and evaluation
   logic [NUM_DIR-1:0] acc_fwd;
   logic [NUM_DIR-1:0] acc_rev;
   logic [NUM_DIR-1:0] dir_allow;
   logic [1:0]         eval;
   logic               pend_dir;
   logic               pend_val;

   // Returns {valid, forward}
   function automatic logic [1:0] fpd_eval(input logic [NUM_DIR-1:0] fwd,
                                           input logic [NUM_DIR-1:0] rev,
                                           input logic [NUM_DIR-1:0] allow);
      logic [NUM_DIR-1:0] ok;
      logic               any_f;
      logic               any_r;
      ok    = (fwd ^ rev) & allow;
      any_f = |(ok & fwd);
      any_r = |(ok & rev);
      if (any_f == any_r) begin
         fpd_eval = 2'b00;
      end else begin
         fpd_eval = {1'b1, any_f};
      end
   endfunction : fpd_eval

   always_comb begin
      for (int i = 0; i < NUM_DIR; i++) begin
         dir_allow[i] = (i < fpd_pkg::NUM_PH_DIR) ? ctrl[fpd_pkg::CTRL_PH_DIR]
                                                 : ctrl[fpd_pkg::CTRL_GND_DIR];
      end
   end

   assign eval = fpd_eval(acc_fwd, acc_rev, dir_allow);

   // Fresh accumulation starts with the first pickup out of idle
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         acc_fwd <= '0;
         acc_rev <= '0;
      end else if (main_idle && any_pickup) begin
         acc_fwd <= dir_fwd_i;
         acc_rev <= dir_rev_i;
      end else if (any_pickup) begin
         acc_fwd <= acc_fwd | dir_fwd_i;
         acc_rev <= acc_rev | dir_rev_i;
      end
   end

   // Snapshot at the end of the activation delay, not live
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pend_val <= 1'b0;
         pend_dir <= 1'b0;
      end else if (main_declare) begin
         pend_val <= eval[1];
         pend_dir <= eval[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Remote direction hold
   logic                      rem_dir;
   logic                      rem_val;
   logic [fpd_pkg::TMR_W-1:0] des_cnt;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || main_bad) begin
         held    <= 1'b0;
         rem_dir <= 1'b0;
         rem_val <= 1'b0;
      end else if (main_fire) begin
         held    <= 1'b1;
         rem_dir <= main_declare ? eval[0] : pend_dir;
         rem_val <= main_declare ? eval[1] : pend_val;
      end else if (main_declare || (held && des_cnt >= fpd_pkg::TMR_W'(des_ms))) begin
         held    <= 1'b0;
         rem_dir <= 1'b0;
         rem_val <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || main_fire || !held) begin
         des_cnt <= '0;
      end else if (tick && !(&des_cnt)) begin
         des_cnt <= des_cnt + fpd_pkg::TMR_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Local indications
   logic                      loc_on;
   logic                      loc_counting;
   logic                      pres_q;
   logic [fpd_pkg::TMR_W-1:0] loc_cnt;
   logic [fpd_pkg::TMR_W-1:0] loc_limit;

   // Local hold setting is in thousandths of a minute, one step is 60 ms
   assign loc_limit = fpd_pkg::TMR_W'(local_steps) * fpd_pkg::TMR_W'(fpd_pkg::MS_PER_LOCAL_STEP);

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pres_q <= 1'b0;
      end else begin
         pres_q <= volt_present_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         loc_on            <= 1'b0;
         local_direction_o <= 1'b0;
         local_valid_o     <= 1'b0;
      end else if (main_fire) begin
         loc_on            <= 1'b1;
         local_direction_o <= main_declare ? eval[0] : pend_dir;
         local_valid_o     <= main_declare ? eval[1] : pend_val;
      end else if (loc_counting && loc_cnt >= loc_limit) begin
         loc_on            <= 1'b0;
         local_direction_o <= 1'b0;
         local_valid_o     <= 1'b0;
      end
   end

   assign local_fault_o = loc_on;

   // Hold starts at the rising edge of voltage presence
   always_ff @(posedge clk_sys_i) begin
      // Set wins, so a voltage return in the firing cycle is kept
      if (rst_i) begin
         loc_counting <= 1'b0;
      end else if (volt_present_i && !pres_q && (loc_on || main_fire)) begin
         loc_counting <= 1'b1;
      end else if (main_fire || !loc_on) begin
         loc_counting <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || main_fire || !loc_counting) begin
         loc_cnt <= '0;
      end else if (tick && !(&loc_cnt)) begin
         loc_cnt <= loc_cnt + fpd_pkg::TMR_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Telecontrol outputs with quality flags
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         fault_passage_pulse_o <= 1'b0;
         fault_direction_out_o <= 1'b0;
         direction_valid_out_o <= 1'b0;
         fault_bad_o           <= 1'b1;
         direction_bad_o       <= 1'b1;
         valid_bad_o           <= 1'b1;
      end else begin
         fault_passage_pulse_o <= main_pulse && !main_bad;
         fault_direction_out_o <= rem_dir && !main_bad;
         direction_valid_out_o <= rem_val && !main_bad;
         fault_bad_o           <= main_bad;
         direction_bad_o       <= main_bad;
         valid_bad_o           <= main_bad;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sens_ground_fault_pulse_o <= 1'b0;
         sens_ground_bad_o         <= 1'b1;
      end else begin
         sens_ground_fault_pulse_o <= sg_pulse && !sg_bad;
         sens_ground_bad_o         <= sg_bad;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register read, data one cycle after the strobe
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !reg_rd_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_addr_i == fpd_pkg::ADDR_CTRL) begin
         reg_rdata_o <= 32'(ctrl);
      end else if (reg_addr_i == fpd_pkg::ADDR_OC_EN) begin
         reg_rdata_o <= 32'(oc_en);
      end else if (reg_addr_i == fpd_pkg::ADDR_ACT) begin
         reg_rdata_o <= 32'(act_ms);
      end else if (reg_addr_i == fpd_pkg::ADDR_PUL) begin
         reg_rdata_o <= 32'(pul_ms);
      end else if (reg_addr_i == fpd_pkg::ADDR_DES) begin
         reg_rdata_o <= 32'(des_ms);
      end else if (reg_addr_i == fpd_pkg::ADDR_LOCAL) begin
         reg_rdata_o <= 32'(local_steps);
      end else if (reg_addr_i == fpd_pkg::ADDR_STATUS) begin
         reg_rdata_o <= 32'({sg_declare, main_idle, started, held, loc_on,
                             rem_val, rem_dir, main_pulse, sg_pulse});
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end
endmodule : fpd_top

// file: fpd_pkg.sv
// Shared constants for the fault passage detector
package fpd_pkg;
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_OC_EN  = 8'h04;
   localparam logic [7:0] ADDR_ACT    = 8'h08;
   localparam logic [7:0] ADDR_PUL    = 8'h0C;
   localparam logic [7:0] ADDR_DES    = 8'h10;
   localparam logic [7:0] ADDR_LOCAL  = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   // Control register fields
   localparam int CTRL_ENABLE  = 0;
   localparam int CTRL_PH_DIR  = 1;
   localparam int CTRL_GND_DIR = 2;
   localparam int CTRL_VP_EN   = 3;
   localparam int CTRL_VA_EN   = 4;
   localparam int CTRL_SG_EN   = 5;
   localparam int CTRL_W       = 6;
   localparam logic [5:0] CTRL_RST = 6'h3E;

   // Unit counts
   localparam int NUM_OC  = 8;
   localparam int NUM_DIR = 4;
   localparam int NUM_PH_DIR = 3;
   localparam logic [7:0] OC_EN_RST = 8'hFF;

   // Timer fields, all in milliseconds except local hold (thousandths of a minute)
   localparam int TMR_W   = 24;
   localparam int ACT_W   = 16;
   localparam int PUL_W   = 16;
   localparam int DES_W   = 22;
   localparam int LOCAL_W = 18;
   localparam logic [15:0] ACT_RST   = 16'h03E8;
   localparam logic [15:0] PUL_RST   = 16'h0001;
   localparam logic [21:0] DES_RST   = 22'h09_27C0;
   localparam logic [17:0] LOCAL_RST = 18'h0_2710;
   localparam int MS_PER_LOCAL_STEP = 60;

   // Timing
   localparam int CLK_HZ    = 200_000_000;
   localparam int TICK_MS   = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int REST_MS   = 2;
   // One extra tick: the first tick may land right after entry
   localparam logic [TMR_W-1:0] REST_TICKS = TMR_W'(REST_MS + 1);
endpackage : fpd_pkg

// file: fpd_tick.sv
// Millisecond tick divider
`timescale 1ns/1ps
module fpd_tick #(
   parameter int TICK_CYCLES = fpd_pkg::TICK_CYCLES
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   output logic      tick_o
);
   logic [31:0] cnt;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || cnt == 32'(TICK_CYCLES - 1)) begin
         cnt <= 32'h0000_0000;
      end else begin
         cnt <= cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= (cnt == 32'(TICK_CYCLES - 1));
      end
   end
endmodule : fpd_tick

// file: fpd_seq.sv
// Fault passage timing sequence: pickup, activation delay, rest, pulse
`timescale 1ns/1ps
module fpd_seq (
   input  wire logic                     clk_sys_i,
   input  wire logic                     rst_i,
   input  wire logic                     run_i,
   input  wire logic                     tick_i,
   input  wire logic                     pickup_i,
   input  wire logic                     absent_i,
   input  wire logic                     hold_busy_i,
   input  wire logic [fpd_pkg::ACT_W-1:0] act_ms_i,
   input  wire logic [fpd_pkg::PUL_W-1:0] pul_ms_i,
   output logic                          idle_o,
   output logic                          declare_o,
   output logic                          fire_o,
   output logic                          pulse_o
);
   typedef enum logic [4:0] {
      FPD_IDLE   = 5'b00001,
      FPD_PICKUP = 5'b00010,
      FPD_ACT    = 5'b00100,
      FPD_REST   = 5'b01000,
      FPD_PULSE  = 5'b10000
   } fpd_state_t;

   fpd_state_t            state;
   logic [fpd_pkg::TMR_W-1:0] cnt;
   logic                  act_done;
   logic                  rest_done;
   logic                  pul_done;

   assign act_done  = cnt >= fpd_pkg::TMR_W'(act_ms_i);
   assign rest_done = cnt >= fpd_pkg::REST_TICKS;
   assign pul_done  = cnt >= fpd_pkg::TMR_W'(pul_ms_i);
   assign idle_o    = (state == FPD_IDLE);
   assign declare_o = (state == FPD_ACT) && act_done && absent_i;
   assign fire_o    = (declare_o && !hold_busy_i) || ((state == FPD_REST) && rest_done);
   assign pulse_o   = (state == FPD_PULSE);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !run_i) begin
         state <= FPD_IDLE;
      end else begin
         case (state)
            FPD_IDLE: begin
               if (pickup_i) begin
                  state <= FPD_PICKUP;
               end
            end
            FPD_PICKUP: begin
               if (!pickup_i) begin
                  state <= FPD_ACT;
               end
            end
            FPD_ACT: begin
               if (act_done) begin
                  if (!absent_i) begin
                     state <= FPD_IDLE;
                  end else if (hold_busy_i) begin
                     state <= FPD_REST;
                  end else begin
                     state <= FPD_PULSE;
                  end
               end
            end
            FPD_REST: begin
               if (rest_done) begin
                  state <= FPD_PULSE;
               end
            end
            FPD_PULSE: begin
               if (pul_done) begin
                  state <= FPD_IDLE;
               end
            end
            default: begin
               state <= FPD_IDLE;
            end
         endcase
      end
   end

   // Timer restarts on every state change
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !run_i) begin
         cnt <= '0;
      end else if ((state == FPD_IDLE) || (state == FPD_PICKUP && !pickup_i)
                   || (state == FPD_ACT && act_done) || (state == FPD_REST && rest_done)) begin
         cnt <= '0;
      end else if (tick_i && !(&cnt)) begin
         cnt <= cnt + fpd_pkg::TMR_W'(1);
      end
   end
endmodule : fpd_seq

// file: fpd_asserts.sv
// Port checker for the fault passage detector
`timescale 1ns/1ps
module fpd_asserts #(
   parameter int NUM_OC = 8
) (
   input wire logic              clk_sys_i,
   input wire logic              rst_i,
   input wire logic              reg_rd_i,
   input wire logic [31:0]       reg_rdata_o,
   input wire logic [NUM_OC-1:0] oc_pickup_i,
   input wire logic              self_check_ok_i,
   input wire logic              start_event_o,
   input wire logic              fault_passage_pulse_o,
   input wire logic              fault_direction_out_o,
   input wire logic              direction_valid_out_o,
   input wire logic              sens_ground_fault_pulse_o,
   input wire logic              fault_bad_o,
   input wire logic              direction_bad_o,
   input wire logic              valid_bad_o,
   input wire logic              sens_ground_bad_o,
   input wire logic              local_fault_o,
   input wire logic              local_valid_o,
   input wire logic              local_direction_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_fire;
      $rose(fault_passage_pulse_o);
   endsequence
   AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data not idle");
   AST_BAD_ZERO: assert property (fault_bad_o |-> !(fault_passage_pulse_o
      || fault_direction_out_o || direction_valid_out_o)) else $error("invalid output not zero");
   AST_BAD_SAME: assert property (fault_bad_o == direction_bad_o
      && fault_bad_o == valid_bad_o) else $error("quality flags differ");
   AST_SG_ZERO: assert property (sens_ground_bad_o |-> !sens_ground_fault_pulse_o)
      else $error("ground pulse while invalid");
   AST_DIR_VALID: assert property (fault_direction_out_o |-> direction_valid_out_o)
      else $error("direction without valid");
   AST_LOC_DIR: assert property (local_direction_o |-> local_valid_o && local_fault_o)
      else $error("local direction without valid");
   AST_LOCAL: assert property (s_fire |-> local_fault_o)
      else $error("local indication missing");
   AST_DROP: assert property (s_fire |-> $past(oc_pickup_i) == '0)
      else $error("pulse while pickup high");
   AST_START: assert property (start_event_o |-> $past(self_check_ok_i) ##1 !start_event_o)
      else $error("bad start event");
endmodule : fpd_asserts
bind fpd_top fpd_asserts #(.NUM_OC(NUM_OC)) u_fpd_asserts (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .oc_pickup_i(oc_pickup_i), .self_check_ok_i(self_check_ok_i), .start_event_o(start_event_o),
   .fault_passage_pulse_o(fault_passage_pulse_o), .fault_direction_out_o(fault_direction_out_o),
   .direction_valid_out_o(direction_valid_out_o), .fault_bad_o(fault_bad_o),
   .sens_ground_fault_pulse_o(sens_ground_fault_pulse_o), .direction_bad_o(direction_bad_o),
   .valid_bad_o(valid_bad_o), .sens_ground_bad_o(sens_ground_bad_o), .local_fault_o(local_fault_o),
   .local_valid_o(local_valid_o), .local_direction_o(local_direction_o));

// file: fpd_tc_model.sv
// Telecontrol receiver model: pulse width and direction rest gap
`timescale 1ns/1ps
module fpd_tc_model (
   input  wire logic clk_sys_i,
   input  wire logic pulse_i,
   input  wire logic valid_i,
   output int        width_o,
   output int        gap_o
);
   int run = 0;
   int low = 0;
   // Width latched at the fall so readers only see whole pulses
   always @(posedge clk_sys_i) begin
      run <= pulse_i ? run + 1 : 0;
      low <= valid_i ? 0 : low + 1;
      if (pulse_i && run == 0) gap_o <= low;
      if (!pulse_i && run != 0) width_o <= run;
   end
endmodule : fpd_tc_model

// file: fpd_top_tb.sv
// Self-checking bench for the fault passage detector
`timescale 1ns/1ps
module fpd_top_tb;
   logic clk_sys = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, sg = 1'b0;
   logic absent = 1'b0, present = 1'b1;
   logic [7:0] addr = 8'h00, oc = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] fwd = 4'h0, rev = 4'h0;
   logic pulse, dir, valid, sgp, finv, sginv, lf, se, lv, ld, ok = 1'b0;
   int width, gap, n, k, n_errors = 0, comparisons = 0;
   // Rows: control, forward, reverse, expected direction and valid
   logic [19:0] rows [7] = '{20'h3_F103, 20'h3_F021, 20'h3_F140, 20'h3_F330,
                             20'h3_F803, 20'h3_B800, 20'h3_D181};
   always #2.5 clk_sys = ~clk_sys;
   fpd_top #(.TICK_CYCLES(10)) u_fpd_top (.clk_sys_i(clk_sys), .rst_i(rst),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
      .reg_rdata_o(rdata), .oc_pickup_i(oc), .sg_pickup_i(sg), .dir_fwd_i(fwd),
      .dir_rev_i(rev), .volt_absent_i(absent), .volt_present_i(present),
      .self_check_ok_i(ok), .start_event_o(se), .fault_passage_pulse_o(pulse),
      .fault_direction_out_o(dir), .direction_valid_out_o(valid),
      .sens_ground_fault_pulse_o(sgp), .fault_bad_o(finv), .direction_bad_o(),
      .valid_bad_o(), .sens_ground_bad_o(sginv), .local_fault_o(lf),
      .local_valid_o(lv), .local_direction_o(ld));
   fpd_tc_model u_fpd_tc_model (.clk_sys_i(clk_sys), .pulse_i(pulse), .valid_i(valid),
      .width_o(width), .gap_o(gap));
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      comparisons++;
      if (got !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, e);
      end
   endtask : chk
   task automatic rng(input int v, input int lo, input int hi);
      chk(32'(v >= lo && v <= hi), 32'h1);
   endtask : rng
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_sys);
      wr_s <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys);
      rd_s <= 1'b0;
      @(posedge clk_sys);
      chk(rdata, e);
   endtask : rd
   // Flags shown for one cycle only, so only latching can report them
   task automatic fault(input logic [7:0] o, input logic s, input logic [3:0] f,
                        input logic [3:0] r, input logic a);
      oc <= o;
      sg <= s;
      absent <= 1'b0;
      @(posedge clk_sys);
      fwd <= f;
      rev <= r;
      @(posedge clk_sys);
      fwd <= 4'h0;
      rev <= 4'h0;
      repeat (4) @(posedge clk_sys);
      oc <= 8'h00;
      sg <= 1'b0;
      absent <= a;
      present <= 1'b0;
   endtask : fault
   task automatic wait_lvl(input int sel, input logic lvl, input int lim);
      for (n = 0; n < lim; n++) begin
         @(posedge clk_sys);
         if ((sel == 0 ? pulse : sel == 1 ? sgp : lf) === lvl) break;
      end
      if (n == lim) begin
         n_errors++;
         $display("mismatch at %0t: wait ran out", $time);
         wrap_up();
      end
   endtask : wait_lvl
   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(fpd_pkg::ADDR_CTRL, 32'(fpd_pkg::CTRL_RST));
      rd(fpd_pkg::ADDR_OC_EN, 32'(fpd_pkg::OC_EN_RST));
      rd(fpd_pkg::ADDR_PUL, 32'(fpd_pkg::PUL_RST));
      rd(fpd_pkg::ADDR_DES, 32'(fpd_pkg::DES_RST));
      rd(fpd_pkg::ADDR_LOCAL, 32'(fpd_pkg::LOCAL_RST));
      rd(8'h1C, 32'h0);
      rd(fpd_pkg::ADDR_STATUS, 32'h0000_0080);
      chk(32'({finv, sginv, se}), 32'h6);
      ok <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk(32'(se), 32'h1);
      wr(fpd_pkg::ADDR_ACT, 32'h3);
      wr(fpd_pkg::ADDR_PUL, 32'h4);
      wr(fpd_pkg::ADDR_DES, 32'h14);
      wr(fpd_pkg::ADDR_LOCAL, 32'h1);
      rd(fpd_pkg::ADDR_PUL, 32'h4);
      for (k = 0; k < 7; k++) begin
         wr(fpd_pkg::ADDR_CTRL, 32'(rows[k][19:12]));
         fault(8'h05, 1'b0, rows[k][11:8], rows[k][7:4], 1'b1);
         wait_lvl(0, 1'b1, 300);
         chk(32'({dir, valid}), 32'(rows[k][1:0]));
         chk(32'(lf), 32'h1);
         chk(32'({ld, lv}), 32'(rows[k][1:0]));
         wait_lvl(0, 1'b0, 300);
         @(posedge clk_sys);
         rng(width, 31, 41);
         rng(gap, 20, 99999);
      end
      present <= 1'b1;
      wait_lvl(2, 1'b0, 700);
      rng(n, 580, 615);
      fault(8'h00, 1'b1, 4'h0, 4'h0, 1'b1);
      wait_lvl(1, 1'b1, 300);
      chk(32'({sgp, pulse}), 32'h2);
      fault(8'h05, 1'b0, 4'h1, 4'h0, 1'b0);
      repeat (100) begin
         @(posedge clk_sys);
         chk(32'(pulse), 32'h0);
      end
      wr(fpd_pkg::ADDR_CTRL, 32'h1F);
      @(posedge clk_sys);
      chk(32'({finv, sginv}), 32'h1);
      wr(fpd_pkg::ADDR_CTRL, 32'h37);
      @(posedge clk_sys);
      chk(32'({finv, sginv}), 32'h3);
      wr(fpd_pkg::ADDR_CTRL, 32'h3F);
      wr(fpd_pkg::ADDR_OC_EN, 32'h0);
      @(posedge clk_sys);
      chk(32'({finv, sginv}), 32'h2);
      wrap_up();
   end
endmodule : fpd_top_tb
